// >>> rtl/trig_pkg.sv
// Function
// - Up to four trigger pins, each individually set as input or output.
// - Every pin level is readable at all times, whatever its direction.
// - An input pin samples its level for use as an external trigger.
// - Constant-low mode holds the pin low regardless of exposure.
// - Constant-high mode holds the pin high regardless of exposure.
// - Low-during-exposure mode rests high, low exactly during exposure.
// - High-during-exposure mode rests low, high exactly during exposure.
// - Free-running pulse mode gives 50% duty square wave at programmed period.
// - Pulse-low mode rests high, pulses 50% with programmed period during exposure.
// - Pulse-high mode rests low, pulses 50% with programmed period during exposure.
// - Any input pin is selectable as trigger receiver through a pin number setting.
// - Selected input registers events on rising or falling edge per setting.
// - Active-low reset returns the block to its initial unsaved state.
// - Asynchronous mode: a trigger selects the spectrum now being exposed.
// - Synchronous mode: a trigger selects the spectrum after the current one.
// - Every spectrum read out needs its own separate trigger event.
package trig_pkg;

    localparam int unsigned NUM_PINS    = 4;
    localparam int unsigned PER_W       = 16;
    localparam int unsigned ADDR_W      = 6;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_DIR    = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_MODE   = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_PERIOD = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_TRIG   = 6'h0C;
    localparam logic [ADDR_W-1:0] OFS_LEVEL  = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_STAT   = 6'h14;

    // Trigger control field positions
    localparam int unsigned TRIG_SEL_LSB = 0;
    localparam int unsigned TRIG_EDGE    = 2;
    localparam int unsigned TRIG_EXT     = 3;
    localparam int unsigned TRIG_SYNC    = 4;

    // Status field positions
    localparam int unsigned STAT_PEND  = 0;
    localparam int unsigned STAT_ARMED = 1;

    localparam logic [PER_W-1:0] PERIOD_RST = 16'h0064;
    localparam logic [PER_W-1:0] PERIOD_MIN = 16'h0002;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        OM_LOW       = 3'h0,
        OM_HIGH      = 3'h1,
        OM_LOW_EXP   = 3'h2,
        OM_HIGH_EXP  = 3'h3,
        OM_PULSE     = 3'h4,
        OM_PLOW_EXP  = 3'h5,
        OM_PHIGH_EXP = 3'h6
    } out_mode_e;

    localparam logic [2:0] MODE_RST = 3'h0;
    localparam int unsigned MODE_W  = 3;

endpackage

// >>> rtl/pulse_gen.sv
`timescale 1ns/1ps
module pulse_gen
    import trig_pkg::*;
#(
    parameter int unsigned W = PER_W
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         run,
    input  wire logic [W-1:0] period,
    output logic              wave
);
    logic [W-1:0] cnt_q, cnt_d;
    logic         wave_q, wave_d;
    logic [W-1:0] half;

    assign half = (period < W'(PERIOD_MIN)) ? W'(1) : (period >> 1);
    assign wave = wave_q;

    always_comb begin
        cnt_d  = cnt_q;
        wave_d = wave_q;
        if (!run) begin
            cnt_d  = '0;
            wave_d = 1'b0;
        end else if (cnt_q >= half - W'(1)) begin
            cnt_d  = '0;
            wave_d = ~wave_q;
        end else begin
            cnt_d  = cnt_q + W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q  <= '0;
            wave_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            wave_q <= wave_d;
        end
    end

    property p_pulse_rest;
        @(posedge aclk) disable iff (!aresetn)
        !run |=> !wave_q;
    endproperty
    a_pulse_rest: assert property (p_pulse_rest) else $error("pulse not at rest");
endmodule

// >>> rtl/trigger_pin_controller.sv
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module trigger_pin_controller
    import trig_pkg::*;
#(
    parameter int unsigned N = NUM_PINS
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire logic [N-1:0]  trig_in,
    output logic [N-1:0]       trig_out,
    output logic [N-1:0]       trig_oe,
    input  wire logic          exposure,
    input  wire logic          exp_start,
    input  wire logic          exp_end,
    input  wire logic          spectrum_done,
    output logic               readout_req,
    output logic               trig_event
);
    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    logic [N-1:0]        dir_q, dir_d;
    logic [MODE_W*N-1:0] mode_q, mode_d;
    logic [PER_W-1:0]    per_q, per_d;
    logic [4:0]          trg_q, trg_d;
    logic                aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic [ADDR_W-1:0]   awa_q, awa_d;
    logic [31:0]         wd_q, wd_d;
    logic [3:0]          ws_q, ws_d;
    logic                bv_q, bv_d, rv_q, rv_d;
    logic [1:0]          br_q, br_d, rr_q, rr_d;
    logic [31:0]         rd_q, rd_d;

    logic [N-1:0] s1_q, s2_q, s3_q;
    logic         pend_q, pend_d, armed_q, armed_d, req_q, req_d;
    logic [N-1:0] pin_lvl;
    logic         pwave;
    logic         wr_go, rd_go;
    logic [ADDR_W-1:0] wa;
    logic [31:0]       wdat;

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a == OFS_DIR) || (a == OFS_MODE) || (a == OFS_PERIOD) ||
                 (a == OFS_TRIG) || (a == OFS_LEVEL) || (a == OFS_STAT);
    endfunction

    // -----------------------------------------------------------------
    // AXI4-Lite slave
    // -----------------------------------------------------------------
    assign s_axi_awready = !aw_hold_q && !bv_q;
    assign s_axi_wready  = !w_hold_q && !bv_q;
    assign s_axi_arready = !rv_q;
    assign s_axi_bvalid  = bv_q;
    assign s_axi_bresp   = br_q;
    assign s_axi_rvalid  = rv_q;
    assign s_axi_rresp   = rr_q;
    assign s_axi_rdata   = rd_q;

    assign wa    = aw_hold_q ? awa_q : s_axi_awaddr;
    assign wdat  = w_hold_q ? wd_q : s_axi_wdata;
    assign wr_go = (aw_hold_q || (s_axi_awvalid && s_axi_awready)) &&
                   (w_hold_q || (s_axi_wvalid && s_axi_wready));
    assign rd_go = s_axi_arvalid && s_axi_arready;

    always_comb begin
        aw_hold_d = aw_hold_q;
        w_hold_d  = w_hold_q;
        awa_d = awa_q;
        wd_d  = wd_q;
        ws_d  = ws_q;
        bv_d  = bv_q;
        br_d  = br_q;
        dir_d = dir_q;
        mode_d = mode_q;
        per_d = per_q;
        trg_d = trg_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_d = 1'b1;
            wd_d = s_axi_wdata;
            ws_d = s_axi_wstrb;
        end
        if (bv_q && s_axi_bready) begin
            bv_d = 1'b0;
        end
        if (wr_go) begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bv_d = 1'b1;
            br_d = mapped(wa) ? RESP_OKAY : RESP_SLVERR;
            if (wa == OFS_DIR) begin
                dir_d = wdat[N-1:0];
            end
            if (wa == OFS_MODE) begin
                mode_d = wdat[MODE_W*N-1:0];
            end
            if (wa == OFS_PERIOD) begin
                per_d = wdat[PER_W-1:0];
            end
            if (wa == OFS_TRIG) begin
                trg_d = wdat[4:0];
            end
        end
    end

    always_comb begin
        rv_d = rv_q;
        rr_d = rr_q;
        rd_d = rd_q;
        if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
        end
        if (rd_go) begin
            rv_d = 1'b1;
            rr_d = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            rd_d = '0;
            unique case (s_axi_araddr)
                OFS_DIR:    rd_d[N-1:0] = dir_q;
                OFS_MODE:   rd_d[MODE_W*N-1:0] = mode_q;
                OFS_PERIOD: rd_d[PER_W-1:0] = per_q;
                OFS_TRIG:   rd_d[4:0] = trg_q;
                OFS_LEVEL:  rd_d[N-1:0] = pin_lvl;
                OFS_STAT: begin
                    rd_d[STAT_PEND]  = pend_q;
                    rd_d[STAT_ARMED] = armed_q;
                end
                default:    rd_d = '0;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Pin output modes
    // -----------------------------------------------------------------
    logic gated_run;
    assign gated_run = exposure;

    // free-running and gated share one generator each
    logic pwave_free;
    pulse_gen #(.W(PER_W)) u_free (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (1'b1),
        .period  (per_q),
        .wave    (pwave_free)
    );
    pulse_gen #(.W(PER_W)) u_gated (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (gated_run),
        .period  (per_q),
        .wave    (pwave)
    );

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_pin
            logic [2:0] m;
            logic       o;
            assign m = mode_q[MODE_W*gi +: MODE_W];
            always_comb begin
                unique case (m)
                    OM_LOW:       o = 1'b0;
                    OM_HIGH:      o = 1'b1;
                    OM_LOW_EXP:   o = !exposure;
                    OM_HIGH_EXP:  o = exposure;
                    OM_PULSE:     o = pwave_free;
                    OM_PLOW_EXP:  o = !pwave;
                    OM_PHIGH_EXP: o = pwave;
                    default:      o = 1'b0;
                endcase
            end
            assign trig_out[gi] = o;
            assign trig_oe[gi]  = dir_q[gi];
            assign pin_lvl[gi]  = dir_q[gi] ? o : s2_q[gi];
        end
    endgenerate

    // -----------------------------------------------------------------
    // Trigger input
    // -----------------------------------------------------------------
    logic [1:0] sel;
    logic       cur, prev, edge_hit;
    assign sel = trg_q[TRIG_SEL_LSB +: 2];
    assign cur  = s2_q[sel];
    assign prev = s3_q[sel];
    assign edge_hit = trg_q[TRIG_EXT] && !dir_q[sel] &&
                      (trg_q[TRIG_EDGE] ? (!cur && prev) : (cur && !prev));
    assign trig_event  = edge_hit;
    assign readout_req = req_q;

    always_comb begin
        pend_d  = pend_q;
        armed_d = armed_q;
        req_d   = 1'b0;
        if (spectrum_done) begin
            pend_d = 1'b0;
        end
        if (trg_q[TRIG_SYNC]) begin
            // arm, then wait for next exposure start
            if (armed_q && exp_start) begin
                armed_d = 1'b0;
                pend_d  = 1'b1;
            end
            if (edge_hit && !armed_q && !pend_q) begin
                armed_d = 1'b1;
            end
            if (pend_q && exp_end && !spectrum_done) begin
                req_d = 1'b1;
            end
        end else begin
            armed_d = 1'b0;
            if (edge_hit && !pend_q) begin
                pend_d = 1'b1;
            end
            if (pend_q && exp_end && !spectrum_done) begin
                req_d = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_q <= '0;
            mode_q <= '0;
            per_q <= PERIOD_RST;
            trg_q <= '0;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awa_q <= '0;
            wd_q <= '0;
            ws_q <= '0;
            bv_q <= 1'b0;
            br_q <= RESP_OKAY;
            rv_q <= 1'b0;
            rr_q <= RESP_OKAY;
            rd_q <= '0;
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            pend_q <= 1'b0;
            armed_q <= 1'b0;
            req_q <= 1'b0;
        end else begin
            dir_q <= dir_d;
            mode_q <= mode_d;
            per_q <= per_d;
            trg_q <= trg_d;
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rr_q <= rr_d;
            rd_q <= rd_d;
            s1_q <= trig_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pend_q <= pend_d;
            armed_q <= armed_d;
            req_q <= req_d;
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    property p_low_exp;
        @(posedge aclk) disable iff (!aresetn)
        (mode_q[MODE_W*2 +: MODE_W] == OM_LOW_EXP) |-> (trig_out[2] == !exposure);
    endproperty
    a_low_exp: assert property (p_low_exp) else $error("low-exp wrong");
    property p_high_exp;
        @(posedge aclk) disable iff (!aresetn)
        (mode_q[MODE_W*3 +: MODE_W] == OM_HIGH_EXP) |-> (trig_out[3] == exposure);
    endproperty
    a_high_exp: assert property (p_high_exp) else $error("high-exp wrong");
    property p_const;
        @(posedge aclk) disable iff (!aresetn)
        (mode_q[MODE_W*1 +: MODE_W] == OM_HIGH) |-> trig_out[1];
    endproperty
    a_const: assert property (p_const) else $error("const high wrong");
    property p_const_lo;
        @(posedge aclk) disable iff (!aresetn)
        (mode_q[2:0] == OM_LOW) |-> !trig_out[0];
    endproperty
    a_const_lo: assert property (p_const_lo) else $error("const low wrong");
    property p_rest_hi;
        @(posedge aclk) disable iff (!aresetn)
        (mode_q[MODE_W*1 +: MODE_W] == OM_PLOW_EXP) && !exposure && !$past(exposure)
            |-> trig_out[1];
    endproperty
    a_rest_hi: assert property (p_rest_hi) else $error("pulse-low rest wrong");
    property p_oe;
        @(posedge aclk) disable iff (!aresetn)
        (wr_go && (wa == OFS_DIR)) |=> (trig_oe == $past(wdat[N-1:0]));
    endproperty
    a_oe: assert property (p_oe) else $error("direction wrong");
    sequence s_rise;
        trig_in[0] ##1 trig_in[0] ##1 trig_in[0];
    endsequence
    property p_sync;
        @(posedge aclk) disable iff (!aresetn)
        s_rise |-> s2_q[0];
    endproperty
    a_sync: assert property (p_sync) else $error("sync wrong");
    property p_evt_one;
        @(posedge aclk) disable iff (!aresetn)
        trig_event |=> !trig_event;
    endproperty
    a_evt_one: assert property (p_evt_one) else $error("event too long");
    property p_lvl;
        @(posedge aclk) disable iff (!aresetn)
        dir_q[0] |-> (pin_lvl[0] == trig_out[0]);
    endproperty
    a_lvl: assert property (p_lvl) else $error("level wrong");
endmodule

// >>> test/ext_equipment.sv
`timescale 1ns/1ps
module ext_equipment
    import trig_pkg::*;
(
    input  wire logic [NUM_PINS-1:0] trig_out,
    input  wire logic [NUM_PINS-1:0] trig_oe,
    output logic      [NUM_PINS-1:0] trig_in
);
    // ------------------------------
    // Far-side trigger source
    // ------------------------------
    logic [NUM_PINS-1:0] src_q;

    initial src_q = '0;

    // Source changes only right after an edge
    task automatic drive(input int i, input logic v);
        src_q[i] <= v;
    endtask

    // Wire level: device drive wins where enabled
    assign trig_in = (trig_oe & trig_out) | (~trig_oe & src_q);
endmodule

// >>> test/test_trigger_pin_controller.sv
`timescale 1ns/1ps
module test_trigger_pin_controller;
    import trig_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, trig_event, readout_req;
    logic        exposure, exp_start, exp_end, spectrum_done;
    logic [5:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [3:0]  trig_in, trig_out, trig_oe;
    int          fails, tests_run, ev_cnt, rd_cnt, cyc;

    trigger_pin_controller trigger_pin_controller_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .trig_in(trig_in), .trig_out(trig_out), .trig_oe(trig_oe), .exposure(exposure),
        .exp_start(exp_start), .exp_end(exp_end), .spectrum_done(spectrum_done),
        .readout_req(readout_req), .trig_event(trig_event));

    ext_equipment ext_equipment_inst (.trig_out(trig_out), .trig_oe(trig_oe), .trig_in(trig_in));

    // ------------------------------
    // Clock, monitors, watchdog
    // ------------------------------
    initial aclk = 0;
    always #50 aclk = ~aclk;

    always @(posedge aclk) begin
        if (trig_event === 1'b1) ev_cnt++;
        if (readout_req === 1'b1) rd_cnt++;
        cyc++;
        if (cyc == 5000) begin
            fails++;
            results();
        end
    end

    task results;
        if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    // ------------------------------
    // Bus and stimulus helpers
    // ------------------------------
    task do_reset;
        aresetn <= 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
    endtask

    task wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw, w;
        aw = 0;
        w = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) begin
                aw = 1;
                awvalid <= 0;
            end
            if (wvalid && wready === 1'b1) begin
                w = 1;
                wvalid <= 0;
            end
        end
        @(posedge aclk);
        while (bvalid !== 1'b1) @(posedge aclk);
        // Ready left high: back-to-back calls only re-drive it to 1, never low
        chk("bresp", er, bresp);
    endtask

    task rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        @(posedge aclk);
        while (arready !== 1'b1) @(posedge aclk);
        arvalid <= 0;
        @(posedge aclk);
        while (rvalid !== 1'b1) @(posedge aclk);
        chk("rdata", e, rdata);
        chk("rresp", er, rresp);
    endtask

    task exp_begin;
        exposure <= 1;
        exp_start <= 1;
        @(posedge aclk);
        exp_start <= 0;
    endtask

    task exp_finish;
        exposure <= 0;
        exp_end <= 1;
        @(posedge aclk);
        exp_end <= 0;
    endtask

    // Skip to a toggle, then time high and low phases
    task half_chk(input int i, input int h);
        logic v;
        int n;
        for (int k = 0; k < 3; k++) begin
            v = trig_out[i];
            n = 0;
            while (trig_out[i] === v && n < 100) begin
                @(posedge aclk);
                n++;
            end
            if (k > 0) chk("half period", h, n);
        end
    endtask

    // ------------------------------
    // Scenarios
    // ------------------------------
    task t_reset_vals;
        wr(OFS_DIR, 32'h0000000F, RESP_OKAY);
        wr(OFS_PERIOD, 32'h00000010, RESP_OKAY);
        do_reset();
        rd(OFS_DIR, 32'h0, RESP_OKAY);
        rd(OFS_MODE, 32'h0, RESP_OKAY);
        rd(OFS_PERIOD, {16'h0, PERIOD_RST}, RESP_OKAY);
        chk("oe", 4'h0, trig_oe);
        wr(6'h18, 32'h1, RESP_SLVERR);
        rd(6'h18, 32'h0, RESP_SLVERR);
    endtask

    task t_out_modes;
        wr(OFS_MODE, {OM_HIGH_EXP, OM_LOW_EXP, OM_HIGH, OM_LOW}, RESP_OKAY);
        wr(OFS_DIR, 32'h0000000F, RESP_OKAY);
        chk("oe", 4'hF, trig_oe);
        chk("out idle", 4'h6, trig_out);
        rd(OFS_LEVEL, 32'h6, RESP_OKAY);
        exp_begin();
        @(posedge aclk);
        chk("out exp", 4'hA, trig_out);
        exp_finish();
        @(posedge aclk);
        chk("out after", 4'h6, trig_out);
    endtask

    task t_pulse;
        wr(OFS_PERIOD, 32'h8, RESP_OKAY);
        wr(OFS_MODE, {OM_LOW, OM_PHIGH_EXP, OM_PLOW_EXP, OM_PULSE}, RESP_OKAY);
        half_chk(0, 4);
        repeat (9) @(posedge aclk);
        chk("gated rest", 3'b001, trig_out[3:1]);
        exp_begin();
        half_chk(1, 4);
        half_chk(2, 4);
        exp_finish();
        @(posedge aclk);
        chk("gated stop", 3'b001, trig_out[3:1]);
    endtask

    task t_async;
        wr(OFS_DIR, 32'h0, RESP_OKAY);
        wr(OFS_TRIG, 32'h2, RESP_OKAY);
        wr(OFS_TRIG, 32'hA, RESP_OKAY);
        ext_equipment_inst.drive(2, 1'b1);
        repeat (6) @(posedge aclk);
        chk("event rise", 1, ev_cnt);
        rd(OFS_LEVEL, 32'h4, RESP_OKAY);
        rd(OFS_STAT, 32'h1, RESP_OKAY);
        ext_equipment_inst.drive(2, 1'b0);
        ext_equipment_inst.drive(1, 1'b1);
        repeat (6) @(posedge aclk);
        chk("no event", 1, ev_cnt);
        exp_begin();
        exp_finish();
        repeat (3) @(posedge aclk);
        chk("readout", 1, rd_cnt);
        spectrum_done <= 1;
        @(posedge aclk);
        spectrum_done <= 0;
        exp_begin();
        exp_finish();
        repeat (3) @(posedge aclk);
        chk("no readout", 1, rd_cnt);
        rd(OFS_STAT, 32'h0, RESP_OKAY);
    endtask

    task t_sync;
        wr(OFS_TRIG, 32'h01, RESP_OKAY);
        wr(OFS_TRIG, 32'h05, RESP_OKAY);
        wr(OFS_TRIG, 32'h1D, RESP_OKAY);
        exp_begin();
        ext_equipment_inst.drive(1, 1'b0);
        repeat (6) @(posedge aclk);
        chk("event fall", 2, ev_cnt);
        exp_finish();
        repeat (3) @(posedge aclk);
        chk("sync wait", 1, rd_cnt);
        rd(OFS_STAT, 32'h2, RESP_OKAY);
        exp_begin();
        exp_finish();
        repeat (3) @(posedge aclk);
        chk("sync readout", 2, rd_cnt);
    endtask

    initial begin
        aresetn = 0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {exposure, exp_start, exp_end, spectrum_done} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        do_reset();
        t_reset_vals();
        t_out_modes();
        t_pulse();
        t_async();
        t_sync();
        results();
    end
endmodule
